// ==== mcu_model.sv ====
// Microcontroller stand-in that services the window watchdog.
// Assumes the watchdog state output of the supervisor, core clock.
`timescale 1ns/1ps
module mcu_model
    import supervisor_pkg::*;
(
    // Clock and controls
    input wire logic clk_i,
    input wire logic en_i,
    input wire logic dup_i,
    input wire logic [3:0] dly_i,
    // Watchdog side
    input wire wd_state_t state_i,
    output logic wr_o,
    output logic bit_o
);
    wd_state_t seen;
    logic [3:0] left;
    logic go;
    logic fire;
    initial begin
        wr_o = 1'b0;
        fire = 1'b0;
        bit_o = 1'b0;
        seen = WD_IDLE;
        left = 4'h0;
        go = 1'b0;
    end
    // Slow answers come from dly_i; a late write is still inside the window
    always @(negedge clk_i) begin
        fire = 1'b0;
        if (state_i !== seen) begin
            seen = state_i;
            left = dly_i;
            go = en_i && (seen == WD_LONG || seen == WD_OPEN || (seen == WD_CLOSED && dup_i));
        end
        if (go && left == 4'h0) begin
            go = 1'b0;
            fire = 1'b1;
            if (seen == WD_LONG) begin
                bit_o = 1'b1;
            end else if (seen == WD_OPEN) begin
                bit_o = ~bit_o;
            end
        end else if (left != 4'h0) begin
            left = left - 4'h1;
        end
        wr_o = fire;
    end
endmodule

// ==== supervisor_pkg.sv ====
// Constants, types and timing for the supply supervisor,
// watchdog and operating mode controller.
// Assumes a single 125 MHz core clock.
package supervisor_pkg;

    // ----------------------------------------
    // Clock and time base
    // ----------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int CNT_W = 18;
    localparam int DIV_W = 8;

    // ----------------------------------------
    // Times in microseconds, counts in ticks
    // ----------------------------------------
    localparam int T_SHORT_US = 4000;
    localparam int T_RELEASE_US = 2000;
    localparam int T_LONG_WIN_US = 65000;
    localparam int T_REG_OFF_US = 200000;
    localparam int T_WAKE_US = 56;
    localparam int T_CLOSED_US = 8000;
    localparam int T_OPEN_US = 8000;
    localparam int SHORT_TICKS = (T_SHORT_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int RELEASE_TICKS = (T_RELEASE_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int LONG_WIN_TICKS = (T_LONG_WIN_US * 1000) / TICK_NS;
    localparam int REG_OFF_TICKS = (T_REG_OFF_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int WAKE_TICKS = (T_WAKE_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int CLOSED_TICKS = (T_CLOSED_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int OPEN_TICKS = (T_OPEN_US * 1000) / TICK_NS;

    // ----------------------------------------
    // Limits, indices and reset values
    // ----------------------------------------
    localparam logic [3:0] FAIL_OFF_LIMIT = 4'h8;
    localparam logic [3:0] FAIL_STBY_LIMIT = 4'hF;
    localparam int SUP_MAIN = 0;
    localparam int SUP_REG = 1;
    localparam int SUP_BRIDGE = 2;
    localparam int IN_W = 15;
    localparam logic [3:0] FAIL_CNT_RST = 4'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 18'h00000;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        MODE_ACTIVE = 2'b00,
        MODE_FLASH = 2'b01,
        MODE_REG_STBY = 2'b10,
        MODE_BAT_STBY = 2'b11
    } op_mode_t;

    typedef enum logic [1:0] {
        WD_IDLE = 2'b00,
        WD_LONG = 2'b01,
        WD_CLOSED = 2'b10,
        WD_OPEN = 2'b11
    } wd_state_t;

    typedef struct packed {
        logic [2:0] warn;
        logic [2:0] over;
        logic [2:0] under;
    } supply_t;

    typedef struct packed {
        logic fail_cmp;
        logic below_first;
        logic below_second;
        logic flash_entry_pin;
        logic ignition_wake_pin;
        logic load_high;
    } analog_t;

endpackage

// ==== supply_supervisor_watchdog_modes.sv ====
// Supply flags, regulator supervision, reset output, window
// watchdog and four-state operating mode controller.
// Assumes comparator levels arrive asynchronously and that
// serial-side strobes come from logic on the core clock.
//
// Notes on behaviour
// - Each of three supplies latches warning, overvoltage, undervoltage flags.
// - Read-and-clear drops a supply flag only once its cause is gone.
// - Main or bridge supply overvoltage turns gate drivers off.
// - Supply undervoltage flags never change mode or functions.
// - Regulator below fail level 4 ms while on: battery standby, short flag.
// - Short flag clears only with short gone and battery standby left.
// - Reset output released 2 ms after regulator is on and above threshold.
// - Regulator below selected threshold pulses reset and latches flag.
// - Watchdog failure pulses reset and forces fail-safe, drivers off.
// - Watchdog runs in active; in regulator standby only on high load.
// - After reset release a 65 ms long window awaits a trigger of 1.
// - Toggled trigger inside the open window restarts the next cycle.
// - Eight consecutive failures switch the regulator off for 200 ms.
// - Seven more consecutive failures turn regulator off, battery standby.
// - Watchdog off in flash and in regulator standby with compare set.
// - Disable bit written in flash keeps watchdog off in active mode until reset.
// - Failure, undervoltage or battery wake restart the long window.
// - Rewriting the same trigger value is never a failure.
// - Four modes; flash entered while the flash pin is high.
// - Regulator standby: drivers off; wake returns active with 56 us pulse.
// - Standby request with target select enters the chosen standby.
// - Battery standby: regulator off, wake returns active, state kept.
`timescale 1ns/1ps
module supply_supervisor_watchdog_modes
    import supervisor_pkg::*;
#(
    parameter int SHORT_T = SHORT_TICKS,
    parameter int RELEASE_T = RELEASE_TICKS,
    parameter int LONG_WIN_T = LONG_WIN_TICKS,
    parameter int REG_OFF_T = REG_OFF_TICKS,
    parameter int WAKE_T = WAKE_TICKS,
    parameter int CLOSED_T = CLOSED_TICKS,
    parameter int OPEN_T = OPEN_TICKS
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // Comparator levels, asynchronous
    input wire supply_t SUPPLY_CMP_I,
    input wire analog_t ANALOG_I,
    // Serial-side controls, core clock
    input wire logic WD_TOGGLE_WR_I,
    input wire logic WD_TOGGLE_BIT_I,
    input wire logic WD_DISABLE_BIT_I,
    input wire logic CURRENT_COMPARE_SELECT_I,
    input wire logic RESET_THRESHOLD_SELECT_I,
    input wire logic STANDBY_TARGET_SELECT_I,
    input wire logic STANDBY_REQUEST_I,
    input wire logic SERIAL_ACCESS_I,
    input wire supply_t CLEAR_SUPPLY_I,
    input wire logic CLEAR_REG_UV_I,
    input wire logic CLEAR_REG_SHORT_I,
    // Flags
    output supply_t SUPPLY_FLAGS_O,
    output logic REGULATOR_UNDERVOLTAGE_FLAG_O,
    output logic REGULATOR_SHORT_FLAG_O,
    // Pins and enables
    output logic RESET_OUTPUT_LOW_O,
    output logic WAKE_PULSE_OUT_LOW_O,
    output logic GATE_ENABLE_O,
    output logic PERIPH_ENABLE_O,
    output logic REGULATOR_ON_O,
    // Status
    output op_mode_t MODE_O,
    output wd_state_t WD_STATE_O,
    output logic [3:0] WD_FAIL_COUNT_O
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Three stages; a bit moves only when stages two and three agree
    logic [IN_W-1:0] s1_q, s2_q, s3_q, filt_q;
    wire [IN_W-1:0] filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            filt_q <= '0;
        end else begin
            s1_q <= {SUPPLY_CMP_I, ANALOG_I};
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
        end
    end

    wire supply_t sup = filt_q[IN_W-1:6];
    wire analog_t ana = filt_q[5:0];

    // ----------------------------------------
    // Microsecond tick
    // ----------------------------------------
    logic [DIV_W-1:0] div_q;
    logic tick_q;
    wire div_wrap = div_q == DIV_W'(TICK_CYC - 1);

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_wrap ? '0 : div_q + 1'b1;
            tick_q <= div_wrap;
        end
    end

    // ----------------------------------------
    // State registers and shared wires
    // ----------------------------------------
    op_mode_t mode_q, mode_d;
    wd_state_t wd_q, wd_d;
    supply_t sflag_q, sflag_d;
    logic uv_q, short_q, rst_low_q, wake_n_q;
    logic gate_q, periph_q, reg_on_q, off_run_q;
    logic failsafe_q, wd_dis_q, last_q;
    logic [3:0] fail_cnt_q;
    logic [CNT_W-1:0] short_cnt_q, rst_cnt_q, wd_cnt_q, off_cnt_q, wake_cnt_q;

    wire vdd_low = RESET_THRESHOLD_SELECT_I ? ana.below_second : ana.below_first;
    wire released = rst_low_q;
    wire in_bat = mode_q == MODE_BAT_STBY;
    wire in_reg_stby = mode_q == MODE_REG_STBY;
    wire wake_ev = SERIAL_ACCESS_I | ana.ignition_wake_pin;

    // ----------------------------------------
    // Supply and regulator flags
    // ----------------------------------------
    // Set wins over a clear in the same cycle
    wire supply_t sup_clr = CLEAR_SUPPLY_I & ~sup;
    assign sflag_d = sup | (sflag_q & ~sup_clr);
    wire uv_set = reg_on_q & released & vdd_low;
    wire uv_d = uv_set | (uv_q & ~(CLEAR_REG_UV_I & ~vdd_low));
    wire short_run = reg_on_q & ana.fail_cmp;
    wire short_hit = short_run & tick_q & (short_cnt_q == CNT_W'(SHORT_T - 1));
    wire short_clr = CLEAR_REG_SHORT_I & ~ana.fail_cmp & ~in_bat;
    wire short_d = short_hit | (short_q & ~short_clr);

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    wire act_sup = mode_q == MODE_ACTIVE && !wd_dis_q;
    wire stby_sup = in_reg_stby && !CURRENT_COMPARE_SELECT_I && ana.load_high;
    wire wd_en = released & ~off_run_q & (act_sup | stby_sup);
    wire toggled = WD_TOGGLE_WR_I & (WD_TOGGLE_BIT_I != last_q);
    wire wd_tick = tick_q & (wd_q != WD_IDLE);
    wire long_end = wd_cnt_q == CNT_W'(LONG_WIN_T - 1);
    wire closed_end = wd_cnt_q == CNT_W'(CLOSED_T - 1);
    wire open_end = wd_cnt_q == CNT_W'(OPEN_T - 1);
    wire first_trig = wd_q == WD_LONG && WD_TOGGLE_WR_I && WD_TOGGLE_BIT_I;
    wire open_trig = wd_q == WD_OPEN && toggled;
    wire wd_good = wd_en & (first_trig | open_trig);
    wire early = wd_q == WD_CLOSED && toggled;
    wire late = tick_q & ((wd_q == WD_LONG & long_end) | (wd_q == WD_OPEN & open_end));
    wire wd_fail = wd_en & ~wd_good & (early | late);
    wire [3:0] fail_next = fail_cnt_q + 4'h1;
    wire hit_off = wd_fail & (fail_next == FAIL_OFF_LIMIT);
    wire hit_stby = wd_fail & (fail_next == FAIL_STBY_LIMIT);

    always_comb begin
        wd_d = wd_q;
        if (!wd_en) begin
            wd_d = WD_IDLE;
        end else if (wd_fail) begin
            wd_d = WD_LONG;
        end else if (wd_good) begin
            wd_d = WD_CLOSED;
        end else begin
            case (wd_q)
                WD_IDLE: wd_d = WD_LONG;
                WD_CLOSED: wd_d = (tick_q && closed_end) ? WD_OPEN : WD_CLOSED;
                default: wd_d = wd_q;
            endcase
        end
    end
    wire wd_cnt_clr = wd_d != wd_q || wd_good || wd_fail;

    // ----------------------------------------
    // Operating modes
    // ----------------------------------------
    wire to_bat = short_hit | hit_stby;
    wire op_mode_t reg_target = STANDBY_TARGET_SELECT_I ? MODE_BAT_STBY : MODE_REG_STBY;
    wire stby_wake = in_reg_stby & ~to_bat & wake_ev;
    wire bat_wake = in_bat & wake_ev;

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            MODE_ACTIVE: begin
                if (to_bat) begin
                    mode_d = MODE_BAT_STBY;
                end else if (ana.flash_entry_pin) begin
                    mode_d = MODE_FLASH;
                end else if (STANDBY_REQUEST_I) begin
                    mode_d = reg_target;
                end
            end
            MODE_FLASH: begin
                if (to_bat) begin
                    mode_d = MODE_BAT_STBY;
                end else if (!ana.flash_entry_pin) begin
                    mode_d = MODE_ACTIVE;
                end
            end
            MODE_REG_STBY: begin
                if (to_bat) begin
                    mode_d = MODE_BAT_STBY;
                end else if (wake_ev) begin
                    mode_d = MODE_ACTIVE;
                end
            end
            MODE_BAT_STBY: begin
                if (wake_ev) begin
                    mode_d = MODE_ACTIVE;
                end
            end
            default: mode_d = MODE_ACTIVE;
        endcase
    end

    // Undervoltage flags feed no term below
    wire drive_mode = mode_q == MODE_ACTIVE || mode_q == MODE_FLASH;
    wire periph_d = drive_mode & ~failsafe_q;
    wire ov_cut = sflag_q.over[SUP_MAIN] | sflag_q.over[SUP_BRIDGE];
    wire gate_d = periph_d & ~ov_cut;
    wire reg_on_d = ~in_bat & ~off_run_q;
    wire rst_hold = ~reg_on_q | vdd_low | wd_fail;
    wire rst_done = rst_cnt_q == CNT_W'(RELEASE_T);
    wire off_end = tick_q & (off_cnt_q == CNT_W'(REG_OFF_T - 1));
    wire wake_end = tick_q & (wake_cnt_q == CNT_W'(WAKE_T - 1));

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mode_q <= MODE_ACTIVE;
            sflag_q <= '0;
            uv_q <= 1'b0;
            short_q <= 1'b0;
            short_cnt_q <= CNT_RST;
        end else begin
            mode_q <= mode_d;
            sflag_q <= sflag_d;
            uv_q <= uv_d;
            short_q <= short_d;
            short_cnt_q <= short_run ? short_cnt_q + CNT_W'(tick_q) : CNT_RST;
        end
    end
    // Pin level, low while reset; a pulse after a failure lasts the release delay
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rst_cnt_q <= CNT_RST;
            rst_low_q <= 1'b0;
        end else begin
            rst_cnt_q <= rst_hold ? CNT_RST : rst_cnt_q + CNT_W'(tick_q && !rst_done);
            rst_low_q <= ~rst_hold & rst_done;
        end
    end
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wd_q <= WD_IDLE;
            wd_cnt_q <= CNT_RST;
            last_q <= 1'b0;
            wd_dis_q <= 1'b0;
            failsafe_q <= 1'b0;
        end else begin
            wd_q <= wd_d;
            wd_cnt_q <= wd_cnt_clr ? CNT_RST : wd_cnt_q + CNT_W'(wd_tick);
            last_q <= wd_good ? WD_TOGGLE_BIT_I : last_q;
            wd_dis_q <= wd_dis_q | (mode_q == MODE_FLASH && WD_DISABLE_BIT_I);
            failsafe_q <= wd_fail | (failsafe_q & ~wd_good);
        end
    end
    // Counter survives the regulator off interval on purpose
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            fail_cnt_q <= FAIL_CNT_RST;
            off_run_q <= 1'b0;
            off_cnt_q <= CNT_RST;
        end else begin
            fail_cnt_q <= (wd_good || bat_wake || hit_stby) ? FAIL_CNT_RST : wd_fail ? fail_next : fail_cnt_q;
            off_run_q <= hit_off | (off_run_q & ~off_end & ~in_bat);
            off_cnt_q <= off_run_q ? off_cnt_q + CNT_W'(tick_q) : CNT_RST;
        end
    end
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wake_n_q <= 1'b1;
            wake_cnt_q <= CNT_RST;
            gate_q <= 1'b0;
            periph_q <= 1'b0;
            reg_on_q <= 1'b1;
        end else begin
            wake_n_q <= ~stby_wake & (wake_n_q | wake_end);
            wake_cnt_q <= wake_n_q ? CNT_RST : wake_cnt_q + CNT_W'(tick_q);
            gate_q <= gate_d;
            periph_q <= periph_d;
            reg_on_q <= reg_on_d;
        end
    end

    assign SUPPLY_FLAGS_O = sflag_q;
    assign REGULATOR_UNDERVOLTAGE_FLAG_O = uv_q;
    assign REGULATOR_SHORT_FLAG_O = short_q;
    assign RESET_OUTPUT_LOW_O = rst_low_q;
    assign WAKE_PULSE_OUT_LOW_O = wake_n_q;
    assign GATE_ENABLE_O = gate_q;
    assign PERIPH_ENABLE_O = periph_q;
    assign REGULATOR_ON_O = reg_on_q;
    assign MODE_O = mode_q;
    assign WD_STATE_O = wd_q;
    assign WD_FAIL_COUNT_O = fail_cnt_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);

    AST_SUP_LATCH: assert property ((sup & ~sflag_q) != '0 |=> (sflag_q & $past(sup)) == $past(sup))
        else $error("supply flag missed its cause");
    AST_SUP_HOLD: assert property ((CLEAR_SUPPLY_I & sup) != '0 |=> (sflag_q & $past(sup)) == $past(sup))
        else $error("supply flag cleared while cause present");
    AST_OV_GATE: assert property (ov_cut |=> !GATE_ENABLE_O)
        else $error("gate enabled during overvoltage");
    AST_SHORT: assert property (short_hit |=> in_bat && short_q ##1 !reg_on_q)
        else $error("short did not force battery standby");
    AST_SHORT_KEEP: assert property (short_q && in_bat |=> short_q)
        else $error("short flag cleared in battery standby");
    AST_RELEASE: assert property ($rose(rst_low_q) |-> $past(rst_done) && reg_on_q)
        else $error("reset released early");
    AST_UV_RESET: assert property (reg_on_q && vdd_low |=> !rst_low_q [*2])
        else $error("no reset on regulator undervoltage");
    AST_WD_FAIL: assert property (wd_fail |=> !rst_low_q && failsafe_q ##1 !gate_q)
        else $error("watchdog failure without fail-safe");
    AST_FLASH_OFF: assert property (mode_q == MODE_FLASH |=> wd_q == WD_IDLE)
        else $error("watchdog running in flash mode");
    AST_EIGHT: assert property (wd_fail && fail_cnt_q == 4'h7 |=> off_run_q ##1 !reg_on_q)
        else $error("no regulator off after eight failures");
    AST_FIFTEEN: assert property (wd_fail && fail_cnt_q == 4'hE |=> in_bat)
        else $error("no battery standby after fifteen failures");
    AST_SAME_VALUE: assert property (wd_en && WD_TOGGLE_WR_I && WD_TOGGLE_BIT_I == last_q
        && wd_q != WD_LONG |-> !wd_fail)
        else $error("repeated trigger value counted as failure");
    AST_GOOD_CLR: assert property (wd_good |=> fail_cnt_q == FAIL_CNT_RST && wd_q == WD_CLOSED)
        else $error("correct trigger did not reset counter");
    AST_WAKE: assert property (stby_wake |=> mode_q == MODE_ACTIVE && !wake_n_q)
        else $error("wake from regulator standby missed");

    COV_SHORT: cover property (short_hit);
    COV_GOOD: cover property (wd_q == WD_OPEN && wd_good);
    COV_OFF: cover property ($rose(off_run_q));
    COV_WAKE: cover property ($rose(wake_n_q));

endmodule

// ==== supply_supervisor_watchdog_modes_test.sv ====
// Self-checking bench: supply flags, reset output, watchdog, modes.
// Assumes the package and the microcontroller model compile first.
`timescale 1ns/1ps
module supply_supervisor_watchdog_modes_test;
    import supervisor_pkg::*;
    // ----
    // Signals
    // ----
    localparam int TK = 125;
    localparam int LIMIT = 80000;
    localparam int SH = 8, RL = 4, LW = 10, RO = 10, CW = 4, OW = 6;
    localparam logic [3:0] S_FLG = 4'h0, S_MODE = 4'h1, S_WD = 4'h2, S_CNT = 4'h3, S_RST = 4'h4, S_GATE = 4'h5;
    localparam logic [3:0] S_PER = 4'h6, S_REG = 4'h7, S_WAKE = 4'h8, S_SHORT = 4'h9, S_UV = 4'hA;
    logic clk = 1'b0, rst = 1'b1, wr, tbit, dis = 1'b0, ccs = 1'b0, rts = 1'b0, sts = 1'b0;
    logic sreq = 1'b0, sacc = 1'b0, cuv = 1'b0, csh = 1'b0, en = 1'b1, dup = 1'b0;
    logic uvf, shf, rsn, wkn, gate, per, regon;
    logic [3:0] dly = 4'h0, fcnt;
    supply_t cmp = '0, clr = '0, flags;
    analog_t an = '0;
    op_mode_t mode;
    wd_state_t wds;
    logic [31:0] rnd = 32'hAC4BA21F;
    logic [12:0] note;
    logic [12:0] q[$];
    int mismatches = 0, checks_done = 0, cyc = 0;
    event look;
    always #4 clk = ~clk;
    supply_supervisor_watchdog_modes #(.SHORT_T(SH), .RELEASE_T(RL), .LONG_WIN_T(LW), .REG_OFF_T(RO),
        .CLOSED_T(CW), .OPEN_T(OW)) i_supply_supervisor_watchdog_modes (
        .CORE_CLK_I(clk), .RST_I(rst), .SUPPLY_CMP_I(cmp), .ANALOG_I(an),
        .WD_TOGGLE_WR_I(wr), .WD_TOGGLE_BIT_I(tbit), .WD_DISABLE_BIT_I(dis),
        .CURRENT_COMPARE_SELECT_I(ccs), .RESET_THRESHOLD_SELECT_I(rts),
        .STANDBY_TARGET_SELECT_I(sts), .STANDBY_REQUEST_I(sreq), .SERIAL_ACCESS_I(sacc),
        .CLEAR_SUPPLY_I(clr), .CLEAR_REG_UV_I(cuv), .CLEAR_REG_SHORT_I(csh),
        .SUPPLY_FLAGS_O(flags), .REGULATOR_UNDERVOLTAGE_FLAG_O(uvf), .REGULATOR_SHORT_FLAG_O(shf),
        .RESET_OUTPUT_LOW_O(rsn), .WAKE_PULSE_OUT_LOW_O(wkn), .GATE_ENABLE_O(gate),
        .PERIPH_ENABLE_O(per), .REGULATOR_ON_O(regon), .MODE_O(mode), .WD_STATE_O(wds),
        .WD_FAIL_COUNT_O(fcnt));
    mcu_model i_mcu_model (.clk_i(clk), .en_i(en), .dup_i(dup), .dly_i(dly), .state_i(wds),
        .wr_o(wr), .bit_o(tbit));
    // ----
    // Helpers
    // ----
    function automatic logic [8:0] obs(input logic [3:0] s);
        case (s)
            S_FLG: return flags;
            S_MODE: return {7'h0, mode};
            S_WD: return {7'h0, wds};
            S_CNT: return {5'h0, fcnt};
            S_RST: return {8'h0, rsn};
            S_GATE: return {8'h0, gate};
            S_PER: return {8'h0, per};
            S_REG: return {8'h0, regon};
            S_WAKE: return {8'h0, wkn};
            S_SHORT: return {8'h0, shf};
            default: return {8'h0, uvf};
        endcase
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic chk(input logic [3:0] s, input logic [8:0] e);
        q.push_back({s, e});
        -> look;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Bounded wait, then the same comparison as chk
    task automatic wait_for(input logic [3:0] s, input logic [8:0] e, input int lim);
        int n;
        n = 0;
        while (obs(s) !== e && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk(s, e);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(look) begin
        while (q.size() > 0) begin
            note = q.pop_front();
            checks_done++;
            if (obs(note[12:9]) !== note[8:0]) begin
                mismatches++;
                $display("unexpected at %0t: item %0d got %h want %h", $time, note[12:9], obs(note[12:9]), note[8:0]);
            end
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            mismatches++;
            print_verdict();
        end
    end
    // ----
    // Scenarios
    // ----
    initial begin
        idle(2);
        rst = 1'b0;
        idle(3 * TK);
        chk(S_RST, 9'h0);
        wait_for(S_RST, 9'h1, 2 * TK);
        wait_for(S_WD, {7'h0, WD_CLOSED}, 40);
        chk(S_CNT, 9'h0);
        dup = 1'b1;
        dly = 4'hA;
        idle(40 * TK);
        chk(S_CNT, 9'h0);
        chk(S_RST, 9'h1);
        rts = 1'b1;
        an.below_first = 1'b1;
        idle(20);
        chk(S_UV, 9'h0);
        an.below_second = 1'b1;
        wait_for(S_RST, 9'h0, 20);
        chk(S_UV, 9'h1);
        an.below_second = 1'b0;
        an.below_first = 1'b0;
        wait_for(S_RST, 9'h1, 6 * TK);
        wait_for(S_WD, {7'h0, WD_CLOSED}, 40);
        cuv = 1'b1;
        idle(1);
        cuv = 1'b0;
        idle(2);
        chk(S_UV, 9'h0);
        for (int i = 0; i < 9; i++) begin
            cmp[i] = 1'b1;
            wait_for(S_FLG, 9'h1 << i, 20);
            rnd = xs(rnd);
            clr = rnd[8:0] | (9'h1 << i);
            idle(1);
            clr = '0;
            idle(3);
            chk(S_FLG, 9'h1 << i);
            chk(S_GATE, (i == 3 || i == 5) ? 9'h0 : 9'h1);
            chk(S_MODE, {7'h0, MODE_ACTIVE});
            cmp[i] = 1'b0;
            idle(8);
            clr = rnd[8:0] | (9'h1 << i);
            idle(1);
            clr = '0;
            idle(2);
            chk(S_FLG, 9'h0);
        end
        ccs = 1'b1;
        sreq = 1'b1;
        idle(1);
        sreq = 1'b0;
        wait_for(S_MODE, {7'h0, MODE_REG_STBY}, 4);
        idle(2);
        chk(S_GATE, 9'h0);
        chk(S_PER, 9'h0);
        chk(S_REG, 9'h1);
        wait_for(S_WD, {7'h0, WD_IDLE}, 10);
        sacc = 1'b1;
        idle(1);
        sacc = 1'b0;
        wait_for(S_MODE, {7'h0, MODE_ACTIVE}, 4);
        wait_for(S_WAKE, 9'h0, 4);
        idle((WAKE_TICKS - 2) * TK);
        chk(S_WAKE, 9'h0);
        wait_for(S_WAKE, 9'h1, 3 * TK);
        ccs = 1'b0;
        an.flash_entry_pin = 1'b1;
        wait_for(S_MODE, {7'h0, MODE_FLASH}, 10);
        wait_for(S_WD, {7'h0, WD_IDLE}, 4);
        dis = 1'b1;
        en = 1'b0;
        idle(2);
        dis = 1'b0;
        an.flash_entry_pin = 1'b0;
        wait_for(S_MODE, {7'h0, MODE_ACTIVE}, 10);
        idle(20 * TK);
        chk(S_WD, {7'h0, WD_IDLE});
        chk(S_RST, 9'h1);
        // Second power-on: no servicing, failures pile up
        rst = 1'b1;
        dup = 1'b0;
        idle(2);
        rst = 1'b0;
        cmp[6] = 1'b1;
        idle(10);
        cmp[6] = 1'b0;
        wait_for(S_CNT, 9'h1, 20 * TK);
        idle(2);
        chk(S_RST, 9'h0);
        chk(S_GATE, 9'h0);
        wait_for(S_WD, {7'h0, WD_LONG}, 6 * TK);
        wait_for(S_REG, 9'h0, 120 * TK);
        chk(S_CNT, 9'h8);
        idle(5 * TK);
        chk(S_REG, 9'h0);
        wait_for(S_REG, 9'h1, 8 * TK);
        wait_for(S_MODE, {7'h0, MODE_BAT_STBY}, 120 * TK);
        idle(2);
        chk(S_REG, 9'h0);
        en = 1'b1;
        sacc = 1'b1;
        idle(1);
        sacc = 1'b0;
        wait_for(S_MODE, {7'h0, MODE_ACTIVE}, 4);
        chk(S_WAKE, 9'h1);
        chk(S_FLG, 9'h040);
        wait_for(S_WD, {7'h0, WD_CLOSED}, 8 * TK);
        chk(S_CNT, 9'h0);
        an.fail_cmp = 1'b1;
        wait_for(S_MODE, {7'h0, MODE_BAT_STBY}, 12 * TK);
        chk(S_SHORT, 9'h1);
        an.fail_cmp = 1'b0;
        idle(8);
        csh = 1'b1;
        idle(1);
        csh = 1'b0;
        idle(2);
        chk(S_SHORT, 9'h1);
        an.ignition_wake_pin = 1'b1;
        wait_for(S_MODE, {7'h0, MODE_ACTIVE}, 10);
        an.ignition_wake_pin = 1'b0;
        csh = 1'b1;
        idle(1);
        csh = 1'b0;
        idle(2);
        chk(S_SHORT, 9'h0);
        sts = 1'b1;
        sreq = 1'b1;
        idle(1);
        sreq = 1'b0;
        wait_for(S_MODE, {7'h0, MODE_BAT_STBY}, 4);
        idle(2);
        chk(S_REG, 9'h0);
        idle(2);
        print_verdict();
    end
endmodule
